/* File: design/pfpd_pkg.sv */
// What this block does
// [R1] With operation enable at 0, the two disable bits select unprotected ranges sized by their fields.
// [R2] With operation enable at 1, the two disable bits enable protection of ranges sized by their fields.
// [R3] The high disable bit governs a range ending at 0x7F_FFFF; 0 enables that range, 1 disables it.
// [R4] The high size field (bits 4..3) takes a write only while the high disable bit is 1.
// [R5] The low disable bit governs a range starting at 0x7F_8000; 0 enables that range, 1 disables it.
// [R6] The low size field (bits 1..0) takes a write only while the low disable bit is 1.
// [R7] Enable at 1: both disables 1 protect nothing, a 0 bit protects its range, both 0 protect both.
// [R8] Enable at 0: all flash is protected except each range whose disable bit is 0.
// [R9] Software leaves reserved bit 6 in its erased state; it has no protection function.
// [R10] High size codes 00..11 give 2, 4, 8 or 16 KB ranges ending at the top of flash.
// [R11] A check whose target address lies in a protected area raises the violation flag and is refused.
// [R12] Low size codes pick one of four range sizes from a configurable table, starting at the base.
package pfpd_pkg;

  // Address space of the flash and the two range anchors
  localparam int          ADDR_W       = 23;
  localparam logic [22:0] HIGH_TOP     = 23'h7F_FFFF;
  localparam logic [22:0] LOW_BASE     = 23'h7F_8000;
  localparam logic [22:0] HIGH_MIN_SZ  = 23'h00_0800;

  // Default low range sizes, one per code
  localparam logic [22:0] LOW_SZ0      = 23'h00_0400;
  localparam logic [22:0] LOW_SZ1      = 23'h00_0800;
  localparam logic [22:0] LOW_SZ2      = 23'h00_1000;
  localparam logic [22:0] LOW_SZ3      = 23'h00_2000;

  // Register byte offsets
  localparam logic [7:0] OFF_CFG       = 8'h00;
  localparam logic [7:0] OFF_STAT      = 8'h04;
  localparam logic [7:0] OFF_IEN       = 8'h08;
  localparam logic [7:0] OFF_ICLR      = 8'h0C;
  localparam logic [7:0] OFF_VADDR     = 8'h10;

  // Configuration field positions
  localparam int CFG_OPEN_BIT          = 7;
  localparam int CFG_RSV_BIT           = 6;
  localparam int CFG_HDIS_BIT          = 5;
  localparam int CFG_HS_LSB            = 3;
  localparam int CFG_LDIS_BIT          = 2;
  localparam int CFG_LS_LSB            = 0;

  // Status and event bit positions
  localparam int NUM_EVT               = 2;
  localparam int EVT_VIOL_BIT          = 0;
  localparam int EVT_GRANT_BIT         = 1;

  // Reset values: everything disabled, no protection
  localparam logic [7:0]  CFG_RESET    = 8'hFF;
  localparam logic [1:0]  EVT_RESET    = 2'h0;
  localparam logic [22:0] VADDR_RESET  = 23'h00_0000;

endpackage

/* File: design/pfpd_range_match.sv */
`timescale 1ns/1ps
// Combinational decode of one target address against the configuration
module pfpd_range_match #(
  parameter logic [22:0] LOW_SZ0 = pfpd_pkg::LOW_SZ0,
  parameter logic [22:0] LOW_SZ1 = pfpd_pkg::LOW_SZ1,
  parameter logic [22:0] LOW_SZ2 = pfpd_pkg::LOW_SZ2,
  parameter logic [22:0] LOW_SZ3 = pfpd_pkg::LOW_SZ3
) (
  // Configuration
  input  wire logic [7:0]  cfg,
  // Target
  input  wire logic [22:0] addr,
  // Decode results
  output logic             in_high,
  output logic             in_low,
  output logic             protect
);

  // Half-open window test; size never reaches past the top of space
  function automatic logic in_window(input logic [22:0] a, input logic [22:0] lo,
                                     input logic [22:0] sz);
    logic [23:0] hi;
    hi = {1'b0, lo} + {1'b0, sz};
    in_window = ({1'b0, a} >= {1'b0, lo}) && ({1'b0, a} < hi);
  endfunction

  wire       open_en  = cfg[pfpd_pkg::CFG_OPEN_BIT];
  wire       hdis     = cfg[pfpd_pkg::CFG_HDIS_BIT];
  wire       ldis     = cfg[pfpd_pkg::CFG_LDIS_BIT];
  wire [1:0] hs       = cfg[pfpd_pkg::CFG_HS_LSB +: 2];
  wire [1:0] ls       = cfg[pfpd_pkg::CFG_LS_LSB +: 2];

  // High range doubles per code and ends at the top
  wire [22:0] high_sz = pfpd_pkg::HIGH_MIN_SZ << hs; // R10
  wire [22:0] high_lo = pfpd_pkg::HIGH_TOP - high_sz + 23'h00_0001; // R3
  wire [22:0] low_sz  = (ls == 2'h0) ? LOW_SZ0 :
                        (ls == 2'h1) ? LOW_SZ1 :
                        (ls == 2'h2) ? LOW_SZ2 : LOW_SZ3; // R12

  // A range counts only while its disable bit is 0
  assign in_high = !hdis && in_window(addr, high_lo, high_sz); // R3
  assign in_low  = !ldis && in_window(addr, pfpd_pkg::LOW_BASE, low_sz); // R5
  // Ranges protect with enable set, and carve holes with it clear
  assign protect = open_en ? (in_high || in_low) : !(in_high || in_low); // R1 R2 R7 R8

endmodule

/* File: design/pfpd_top.sv */
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
// Flash protection decode with APB registers and a sequencer check port
module pfpd_top #(
  parameter logic [22:0] LOW_SZ0 = pfpd_pkg::LOW_SZ0,
  parameter logic [22:0] LOW_SZ1 = pfpd_pkg::LOW_SZ1,
  parameter logic [22:0] LOW_SZ2 = pfpd_pkg::LOW_SZ2,
  parameter logic [22:0] LOW_SZ3 = pfpd_pkg::LOW_SZ3
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Sequencer check port
  input  wire logic        chk_valid,
  input  wire logic [22:0] chk_addr,
  output logic             chk_done,
  output logic             chk_refused,
  // Flags
  output logic             protection_violation_flag,
  output logic             irq
);

  logic [7:0]  cfg_q;
  logic [7:0]  cfg_d;
  logic [1:0]  stat_q;
  logic [1:0]  stat_d;
  logic [1:0]  ien_q;
  logic [22:0] vaddr_q;
  logic [31:0] rdata_q;
  logic        err_q;
  logic        done_q;
  logic        refused_q;

  // Bus phases: read data is prepared in setup, so every access ends in one cycle
  wire setup    = psel && !penable;
  wire access   = psel && penable;
  wire wr_acc   = access && pwrite;
  wire hit_cfg  = (paddr == pfpd_pkg::OFF_CFG);
  wire hit_stat = (paddr == pfpd_pkg::OFF_STAT);
  wire hit_ien  = (paddr == pfpd_pkg::OFF_IEN);
  wire hit_iclr = (paddr == pfpd_pkg::OFF_ICLR);
  wire hit_vadr = (paddr == pfpd_pkg::OFF_VADDR);
  wire mapped   = hit_cfg || hit_stat || hit_ien || hit_iclr || hit_vadr;
  wire wr_cfg   = wr_acc && hit_cfg;
  wire wr_ien   = wr_acc && hit_ien;
  wire wr_iclr  = wr_acc && hit_iclr;

  // Read mux; the clear register reads as zero
  wire [31:0] rd_mux = hit_cfg  ? {24'h00_0000, cfg_q} :
                       hit_stat ? {30'h0000_0000, stat_q} :
                       hit_ien  ? {30'h0000_0000, ien_q} :
                       hit_vadr ? {9'h000, vaddr_q} : 32'h0000_0000;

  assign pready  = access;
  assign prdata  = rdata_q;
  assign pslverr = access && err_q;

  // Current stored disable bits gate the size fields
  wire hdis_now = cfg_q[pfpd_pkg::CFG_HDIS_BIT];
  wire ldis_now = cfg_q[pfpd_pkg::CFG_LDIS_BIT];

  // Next configuration: size fields stay frozen while their range is live
  always_comb
  begin
    cfg_d = cfg_q;
    if (wr_cfg)
    begin
      cfg_d[pfpd_pkg::CFG_OPEN_BIT] = pwdata[pfpd_pkg::CFG_OPEN_BIT];
      cfg_d[pfpd_pkg::CFG_RSV_BIT]  = pwdata[pfpd_pkg::CFG_RSV_BIT]; // R9
      cfg_d[pfpd_pkg::CFG_HDIS_BIT] = pwdata[pfpd_pkg::CFG_HDIS_BIT];
      cfg_d[pfpd_pkg::CFG_LDIS_BIT] = pwdata[pfpd_pkg::CFG_LDIS_BIT];
      if (hdis_now)
      begin
        cfg_d[pfpd_pkg::CFG_HS_LSB +: 2] = pwdata[pfpd_pkg::CFG_HS_LSB +: 2]; // R4
      end
      if (ldis_now)
      begin
        cfg_d[pfpd_pkg::CFG_LS_LSB +: 2] = pwdata[pfpd_pkg::CFG_LS_LSB +: 2]; // R6
      end
    end
  end

  // Decode of the address the sequencer presents
  logic in_high;
  logic in_low;
  logic prot;

  pfpd_range_match #(
    .LOW_SZ0 (LOW_SZ0),
    .LOW_SZ1 (LOW_SZ1),
    .LOW_SZ2 (LOW_SZ2),
    .LOW_SZ3 (LOW_SZ3)
  ) u_match (
    .cfg     (cfg_q),
    .addr    (chk_addr),
    .in_high (in_high),
    .in_low  (in_low),
    .protect (prot)
  );

  wire viol_evt  = chk_valid && prot; // R11
  wire grant_evt = chk_valid && !prot;
  wire [1:0] evt = {grant_evt, viol_evt};

  // Sticky status: a new event beats a clear in the same cycle
  always_comb
  begin
    stat_d = stat_q;
    if (wr_iclr)
    begin
      stat_d = stat_q & ~pwdata[1:0];
    end
    stat_d = stat_d | evt; // R11
  end

  // Configuration, enables and status
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_q  <= pfpd_pkg::CFG_RESET;
      ien_q  <= pfpd_pkg::EVT_RESET;
      stat_q <= pfpd_pkg::EVT_RESET;
    end
    else
    begin
      cfg_q  <= cfg_d;
      stat_q <= stat_d;
      if (wr_ien)
      begin
        ien_q <= pwdata[1:0];
      end
    end
  end

  // Bus read data and error, captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end
    else if (setup)
    begin
      rdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      err_q   <= !mapped;
    end
  end

  // Check answer one cycle after the request; first offending address kept
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_q    <= 1'b0;
      refused_q <= 1'b0;
      vaddr_q   <= pfpd_pkg::VADDR_RESET;
    end
    else
    begin
      done_q    <= chk_valid;
      refused_q <= viol_evt; // R11
      if (viol_evt && !stat_q[pfpd_pkg::EVT_VIOL_BIT])
      begin
        vaddr_q <= chk_addr;
      end
    end
  end

  assign chk_done                  = done_q;
  assign chk_refused               = refused_q;
  assign protection_violation_flag = stat_q[pfpd_pkg::EVT_VIOL_BIT];
  // Level interrupt while any enabled status bit stands
  assign irq                       = |(stat_q & ien_q);

  // Checks on the decode and the register side
  wire open_en = cfg_q[pfpd_pkg::CFG_OPEN_BIT];
  wire [1:0] hs_now = cfg_q[pfpd_pkg::CFG_HS_LSB +: 2];
  wire [22:0] hs_lo = pfpd_pkg::HIGH_TOP - (pfpd_pkg::HIGH_MIN_SZ << hs_now) + 23'h00_0001;
  // Software clear of the violation bit; a legal clear may drop the flag
  wire clr_viol = wr_iclr && pwdata[pfpd_pkg::EVT_VIOL_BIT];

  property p_open_map;
    @(posedge pclk) disable iff (!presetn)
      chk_valid && open_en && chk_addr < pfpd_pkg::LOW_BASE |-> !prot;
  endproperty
  a_open_map: assert property (p_open_map) else $error("enabled mode decode wrong"); // R2

  property p_closed_map;
    @(posedge pclk) disable iff (!presetn)
      chk_valid && !open_en && chk_addr < pfpd_pkg::LOW_BASE |-> prot;
  endproperty
  a_closed_map: assert property (p_closed_map) else $error("hole mode decode wrong"); // R1

  property p_no_prot;
    @(posedge pclk) disable iff (!presetn)
      chk_valid && open_en && hdis_now && ldis_now |=> chk_done && !chk_refused;
  endproperty
  a_no_prot: assert property (p_no_prot) else $error("refused with protection off"); // R7

  property p_full_prot;
    @(posedge pclk) disable iff (!presetn)
      chk_valid && !open_en && hdis_now && ldis_now |=> chk_refused;
  endproperty
  a_full_prot: assert property (p_full_prot) else $error("full protection not refused"); // R8

  property p_top_hit;
    @(posedge pclk) disable iff (!presetn)
      !hdis_now && chk_addr == pfpd_pkg::HIGH_TOP |-> in_high;
  endproperty
  a_top_hit: assert property (p_top_hit) else $error("top address outside high range"); // R3

  property p_base_hit;
    @(posedge pclk) disable iff (!presetn)
      chk_addr == pfpd_pkg::LOW_BASE |-> (in_low == !ldis_now);
  endproperty
  a_base_hit: assert property (p_base_hit) else $error("low base decode wrong"); // R5

  property p_high_edge;
    @(posedge pclk) disable iff (!presetn)
      !hdis_now && chk_addr == hs_lo - 23'h00_0001 |-> !in_high;
  endproperty
  a_high_edge: assert property (p_high_edge) else $error("high range too large"); // R10

  property p_hs_lock;
    @(posedge pclk) disable iff (!presetn)
      wr_cfg && !hdis_now |=> $stable(cfg_q[4:3]);
  endproperty
  a_hs_lock: assert property (p_hs_lock) else $error("high size written while live"); // R4

  property p_ls_lock;
    @(posedge pclk) disable iff (!presetn)
      wr_cfg && !ldis_now |=> $stable(cfg_q[1:0]);
  endproperty
  a_ls_lock: assert property (p_ls_lock) else $error("low size written while live"); // R6

  property p_ls_take;
    @(posedge pclk) disable iff (!presetn)
      wr_cfg && ldis_now |=> cfg_q[1:0] == $past(pwdata[1:0]);
  endproperty
  a_ls_take: assert property (p_ls_take) else $error("low size write lost"); // R6

  property p_viol;
    @(posedge pclk) disable iff (!presetn)
      chk_valid && prot |=> chk_refused && protection_violation_flag
        ##1 (protection_violation_flag || $past(clr_viol));
  endproperty
  a_viol: assert property (p_viol) else $error("violation not flagged"); // R11

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
      chk_valid && prot && ien_q[pfpd_pkg::EVT_VIOL_BIT] && !wr_ien |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  property p_evt_wins;
    @(posedge pclk) disable iff (!presetn)
      clr_viol && viol_evt |=> protection_violation_flag;
  endproperty
  a_evt_wins: assert property (p_evt_wins) else $error("clear beat a violation"); // R11

  property p_clear;
    @(posedge pclk) disable iff (!presetn)
      clr_viol && !viol_evt |=> !protection_violation_flag;
  endproperty
  a_clear: assert property (p_clear) else $error("violation flag not cleared");

  property p_vaddr_take;
    @(posedge pclk) disable iff (!presetn)
      viol_evt && !protection_violation_flag |=> vaddr_q == $past(chk_addr);
  endproperty
  a_vaddr_take: assert property (p_vaddr_take) else $error("first address lost"); // R11

  property p_vaddr_keep;
    @(posedge pclk) disable iff (!presetn)
      protection_violation_flag |=> $stable(vaddr_q);
  endproperty
  a_vaddr_keep: assert property (p_vaddr_keep) else $error("first address overwritten"); // R11

  property p_unmapped;
    @(posedge pclk) disable iff (!presetn)
      setup && !mapped ##1 access |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

  property p_answer;
    @(posedge pclk) disable iff (!presetn)
      chk_valid |=> chk_done;
  endproperty
  a_answer: assert property (p_answer) else $error("check not answered"); // R11

  property p_grant;
    @(posedge pclk) disable iff (!presetn)
      chk_valid && !prot |=> chk_done && !chk_refused;
  endproperty
  a_grant: assert property (p_grant) else $error("unprotected target refused"); // R11

  property p_hs_take;
    @(posedge pclk) disable iff (!presetn)
      wr_cfg && hdis_now |=> cfg_q[4:3] == $past(pwdata[4:3]);
  endproperty
  a_hs_take: assert property (p_hs_take) else $error("high size write lost"); // R4

  c_refused: cover property (@(posedge pclk) disable iff (!presetn) chk_refused);
  c_hole: cover property (@(posedge pclk) disable iff (!presetn)
    chk_valid && !open_en && !prot);
  c_lock: cover property (@(posedge pclk) disable iff (!presetn) wr_cfg && !hdis_now);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  c_size_take: cover property (@(posedge pclk) disable iff (!presetn) wr_cfg && hdis_now);

endmodule

/* File: tb/pfpd_seq_model.sv */
`timescale 1ns/1ps
// Flash command sequencer stand-in: one-cycle check requests
module pfpd_seq_model (
  // Clock
  input  wire logic        pclk,
  // Answer from the block
  input  wire logic        chk_done,
  input  wire logic        chk_refused,
  // Request to the block
  output logic             chk_valid,
  output logic [22:0]      chk_addr
);
  initial
  begin
    chk_valid = 1'b0;
    chk_addr  = 23'h00_0000;
  end

  // Pulse one request, then take the answer that stands for one cycle
  task automatic check(input logic [22:0] a, output logic done, output logic refused);
    @(posedge pclk);
    chk_valid <= 1'b1;
    chk_addr  <= a;
    @(posedge pclk);
    chk_valid <= 1'b0;
    chk_addr  <= ~a; // Stale address is not held, so a late sample shows up
    #1;
    done    = chk_done;
    refused = chk_refused;
  endtask
endmodule

/* File: tb/pflash_protection_decode_tb.sv */
`timescale 1ns/1ps
// APB and check-port bench for the flash protection decode
module pflash_protection_decode_tb;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr, chk_valid, chk_done, chk_refused, flag, irq;
  logic [22:0] chk_addr;
  int          errors = 0;
  int          num_checks = 0;
  logic [31:0] rd;
  logic        err, done, refd, exp_r;
  logic        seen_v = 1'b0;
  logic [22:0] first_v;
  logic [7:0]  cfg;
  logic [22:0] low_sz [4] = '{pfpd_pkg::LOW_SZ0, pfpd_pkg::LOW_SZ1,
                              pfpd_pkg::LOW_SZ2, pfpd_pkg::LOW_SZ3};
  logic [22:0] probe [5] = '{23'h7F_F800, 23'h7F_F7FF, 23'h7F_83FF, 23'h7F_8400, 23'h00_0000};

  // Free-running 125 MHz clock
  always #4 pclk = ~pclk;

  pfpd_top dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chk_valid(chk_valid), .chk_addr(chk_addr), .chk_done(chk_done),
    .chk_refused(chk_refused), .protection_violation_flag(flag), .irq(irq)
  );

  pfpd_seq_model seq (
    .pclk(pclk), .chk_done(chk_done), .chk_refused(chk_refused),
    .chk_valid(chk_valid), .chk_addr(chk_addr)
  );

  // Counted comparison
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; waits for pready, only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wcfg(input logic [7:0] c);
    apb(1'b1, pfpd_pkg::OFF_CFG, {24'h00_0000, c});
    cfg = c;
  endtask

  // Expected verdict worked out from the protection table
  function automatic logic prot(input logic [7:0] c, input logic [22:0] a);
    logic hit;
    hit = (!c[5] && a > 23'h7F_FFFF - (23'h00_0800 << c[4:3]))
       || (!c[2] && a >= 23'h7F_8000 && a - 23'h7F_8000 < low_sz[c[1:0]]);
    return c[7] ? hit : !hit;
  endfunction

  task automatic probe_chk(input logic [22:0] a);
    exp_r = prot(cfg, a);
    seq.check(a, done, refd);
    cmp({31'h0, done}, 32'h1);
    cmp({31'h0, refd}, {31'h0, exp_r});
    if (exp_r && !seen_v)
    begin
      first_v = a;
      seen_v  = 1'b1;
    end
  endtask

  // Interrupt line and violation flag, after the edge has landed
  task automatic irq_chk(input logic ei, input logic ef);
    #1;
    cmp({30'h0, irq, flag}, {30'h0, ei, ef});
  endtask

  task automatic print_verdict;
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watchdog far beyond the expected few hundred cycles
  initial
  begin
    #100000;
    errors++;
    print_verdict;
  end

  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, pfpd_pkg::OFF_CFG, 32'h0);
    cmp(rd, 32'h0000_00FF);
    apb(1'b0, pfpd_pkg::OFF_STAT, 32'h0);
    cmp(rd, 32'h0);
    apb(1'b0, pfpd_pkg::OFF_IEN, 32'h0);
    cmp(rd, 32'h0);
    apb(1'b0, pfpd_pkg::OFF_VADDR, 32'h0);
    cmp(rd, 32'h0);
    // Unmapped offset is refused both ways
    apb(1'b1, 8'h14, 32'hFFFF_FFFF);
    cmp({31'h0, err}, 32'h1);
    apb(1'b0, 8'h14, 32'h0);
    cmp({31'h0, err}, 32'h1);
    cmp(rd, 32'h0);
    // Size fields open while disabled, locked once enabled
    wcfg(8'hE4);
    wcfg(8'hC0);
    apb(1'b1, pfpd_pkg::OFF_CFG, 32'h0000_00DB);
    apb(1'b0, pfpd_pkg::OFF_CFG, 32'h0);
    cmp(rd, 32'h0000_00C0);
    // All eight protection modes, reserved bit left erased
    for (int m = 0; m < 8; m++)
    begin
      wcfg({m[2], 1'b1, m[1], 2'b00, m[0], 2'b00});
      foreach (probe[i])
        probe_chk(probe[i]);
    end
    // Every high and low size code at its edges
    for (int k = 0; k < 4; k++)
    begin
      wcfg({5'b1_1_1_00, 1'b1, 2'b00} | {3'b000, k[1:0], 3'b000});
      wcfg({5'b1_1_0_00, 1'b1, 2'b00} | {3'b000, k[1:0], 3'b000});
      probe_chk(23'h7F_FFFF - (23'h00_0800 << k) + 23'h1);
      probe_chk(23'h7F_FFFF - (23'h00_0800 << k));
      wcfg({8'hE4} | {6'h00, k[1:0]});
      wcfg({8'hE0} | {6'h00, k[1:0]});
      probe_chk(23'h7F_8000 + low_sz[k] - 23'h1);
      probe_chk(23'h7F_8000 + low_sz[k]);
    end
    // Sticky status, masking, clearing and first-violation capture
    apb(1'b0, pfpd_pkg::OFF_STAT, 32'h0);
    cmp(rd, 32'h0000_0003);
    apb(1'b0, pfpd_pkg::OFF_VADDR, 32'h0);
    cmp(rd, {9'h000, first_v});
    irq_chk(1'b0, 1'b1);
    apb(1'b1, pfpd_pkg::OFF_IEN, 32'h1);
    irq_chk(1'b1, 1'b1);
    apb(1'b1, pfpd_pkg::OFF_ICLR, 32'h3);
    irq_chk(1'b0, 1'b0);
    apb(1'b0, pfpd_pkg::OFF_STAT, 32'h0);
    cmp(rd, 32'h0);
    probe_chk(23'h00_0000);
    irq_chk(1'b0, 1'b0);
    probe_chk(23'h7F_8000);
    irq_chk(1'b1, 1'b1);
    apb(1'b0, pfpd_pkg::OFF_VADDR, 32'h0);
    cmp(rd, 32'h007F_8000);
    // A clear that lands with a new violation leaves the flag set
    fork
      apb(1'b1, pfpd_pkg::OFF_ICLR, 32'h1);
      begin
        @(posedge pclk);
        seq.check(23'h7F_8000, done, refd);
      end
    join
    cmp({31'h0, refd}, 32'h1);
    irq_chk(1'b1, 1'b1);
    print_verdict;
  end
endmodule
